// [include/tx_cfg_pkg.sv]
// package: register map, field layout and carriers of the transmitter configuration bank
package tx_cfg_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_DRIVER_MODE  = 8'h28;
  localparam logic [7:0]  IDX_CARRIER_AMP  = 8'h29;
  localparam logic [7:0]  IDX_MOD_CONTROL  = 8'h2a;
  localparam logic [7:0]  IDX_OS_LOAD_TRIM = 8'h2b;
  localparam logic [11:0] ADDR_DRIVER_MODE  = {2'h0, IDX_DRIVER_MODE, 2'h0};
  localparam logic [11:0] ADDR_CARRIER_AMP  = {2'h0, IDX_CARRIER_AMP, 2'h0};
  localparam logic [11:0] ADDR_MOD_CONTROL  = {2'h0, IDX_MOD_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_OS_LOAD_TRIM = {2'h0, IDX_OS_LOAD_TRIM, 2'h0};

  // reset values
  localparam logic [7:0] RST_DRIVER_MODE  = 8'h00;
  localparam logic [7:0] RST_CARRIER_AMP  = 8'h00;
  localparam logic [7:0] RST_MOD_CONTROL  = 8'h00;
  localparam logic [7:0] RST_OS_LOAD_TRIM = 8'h00;

  // writable bits; reserved bits stay zero
  localparam logic [7:0] WMASK_DRIVER_MODE  = 8'hcf;
  localparam logic [7:0] WMASK_CARRIER_AMP  = 8'hdf;
  localparam logic [7:0] WMASK_MOD_CONTROL  = 8'hff;
  localparam logic [7:0] WMASK_OS_LOAD_TRIM = 8'hff;

  // field positions
  localparam int DM_INV_TWO   = 7;
  localparam int DM_INV_ONE   = 6;
  localparam int DM_ENABLE    = 3;
  localparam int DM_MODE_LSB  = 0;
  localparam int AMP_LVL_LSB  = 6;
  localparam int AMP_RES_LSB  = 0;
  localparam int MC_OS2_LSB   = 4;
  localparam int MC_CW_MAX    = 3;
  localparam int MC_INVERT    = 2;
  localparam int MC_SEL_LSB   = 0;
  localparam int LT_OS1_LSB   = 4;
  localparam int LT_TRIM_LSB  = 0;

  // driver output mode codes; 3'h3, 3'h6 and 3'h7 are unsupported
  localparam logic [2:0] MODE_HIGH_Z     = 3'h0;
  localparam logic [2:0] MODE_OPEN_DRAIN = 3'h1;
  localparam logic [2:0] MODE_PUSH_PULL  = 3'h2;
  localparam logic [2:0] MODE_FIX_LOW    = 3'h4;
  localparam logic [2:0] MODE_FIX_HIGH   = 3'h5;

  // modulation source codes
  localparam logic [1:0] SRC_NONE     = 2'h0;
  localparam logic [1:0] SRC_ENVELOPE = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h2;

  typedef struct packed {
    logic [1:0] level_reduction;
    logic       cw_max;
    logic [4:0] residual_carrier;
  } amplitude_cfg_t;

  typedef struct packed {
    logic [3:0] first_overshoot_value;
    logic [3:0] second_overshoot_length;
    logic [3:0] load_current_trim;
  } overshoot_cfg_t;

  typedef enum logic [1:0] {OS_IDLE, OS_MOD, OS_EXTEND} os_state_t;

endpackage

// [design/driver_stage.sv]
// one transmitter driver pin: inversion, enable and output mode
`timescale 1ns/1ps
module driver_stage
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       level,
  input  wire logic       invert,
  input  wire logic       enable,
  input  wire logic [2:0] mode,
  output logic            pin_out,
  output logic            pin_oe
);

  logic data;

  assign data = level ^ invert;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end
    else if (!enable)
    begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end
    else
    begin
      case (mode)
        tx_cfg_pkg::MODE_OPEN_DRAIN:
        begin
          pin_out <= 1'b0;
          pin_oe  <= ~data;
        end
        tx_cfg_pkg::MODE_PUSH_PULL:
        begin
          pin_out <= data;
          pin_oe  <= 1'b1;
        end
        tx_cfg_pkg::MODE_FIX_LOW:
        begin
          pin_out <= 1'b0;
          pin_oe  <= 1'b1;
        end
        tx_cfg_pkg::MODE_FIX_HIGH:
        begin
          pin_out <= 1'b1;
          pin_oe  <= 1'b1;
        end
        // unsupported codes float the pin rather than fight the antenna
        default:
        begin
          pin_out <= 1'b0;
          pin_oe  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// [design/transmitter_config_regs.sv]
// transmitter configuration register bank with apb slave and driver control
//
// Function
// - bit 7 of driver mode inverts the second driver pin output.
// - bit 6 of driver mode inverts the first driver pin output.
// - driver enable bit 3 enables both driver pins together.
// - mode bits 2..0 pick open drain, push-pull, high-z, fixed high or low.
// - level reduction bits 7..6 choose 100, 250, 500 or 1000 mV reduction.
// - maximum amplitude bit 3 forces full carrier and ignores level reduction.
// - bits 4..0 of amplitude register set residual carrier percentage.
// - modulation invert bit 2 inverts the selected modulation signal.
// - source select: none, internal envelope, external input, reserved.
// - bits 7..4 of modulation control give extra modulation carrier clocks.
// - bits 7..4 of load register feed the first overshoot timer.
// - bits 3..0 of load register hold the load current trim.
`timescale 1ns/1ps
module transmitter_config_regs
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       carrier_in,
  input  wire logic                       carrier_tick,
  input  wire logic                       internal_transmit_envelope,
  input  wire logic                       external_modulation_in,
  output logic                            driver_pin_one_out,
  output logic                            driver_pin_one_oe,
  output logic                            driver_pin_two_out,
  output logic                            driver_pin_two_oe,
  output logic                            modulation_out,
  output tx_cfg_pkg::amplitude_cfg_t      amplitude_cfg,
  output tx_cfg_pkg::overshoot_cfg_t      overshoot_cfg
);

  //////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] driver_mode;
  logic [7:0] carrier_amplitude;
  logic [7:0] modulation_control;
  logic [7:0] overshoot_and_load_trim;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic       hit;
  logic       setup;
  logic       access;
  logic       wr;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign wr     = access & pwrite;
  assign wbyte  = pwdata[7:0];

  always_comb
  begin
    hit    = 1'b1;
    rd_mux = 8'h00;
    case (paddr)
      tx_cfg_pkg::ADDR_DRIVER_MODE:  rd_mux = driver_mode;
      tx_cfg_pkg::ADDR_CARRIER_AMP:  rd_mux = carrier_amplitude;
      tx_cfg_pkg::ADDR_MOD_CONTROL:  rd_mux = modulation_control;
      tx_cfg_pkg::ADDR_OS_LOAD_TRIM: rd_mux = overshoot_and_load_trim;
      default:                       hit    = 1'b0;
    endcase
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;

  // read data is latched in the setup phase so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup)
      prdata <= {24'h00_0000, rd_mux};
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      driver_mode <= tx_cfg_pkg::RST_DRIVER_MODE;
    else if (wr && paddr == tx_cfg_pkg::ADDR_DRIVER_MODE)
      driver_mode <= wbyte & tx_cfg_pkg::WMASK_DRIVER_MODE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      carrier_amplitude <= tx_cfg_pkg::RST_CARRIER_AMP;
    else if (wr && paddr == tx_cfg_pkg::ADDR_CARRIER_AMP)
      carrier_amplitude <= wbyte & tx_cfg_pkg::WMASK_CARRIER_AMP;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      modulation_control <= tx_cfg_pkg::RST_MOD_CONTROL;
    else if (wr && paddr == tx_cfg_pkg::ADDR_MOD_CONTROL)
      modulation_control <= wbyte & tx_cfg_pkg::WMASK_MOD_CONTROL;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overshoot_and_load_trim <= tx_cfg_pkg::RST_OS_LOAD_TRIM;
    else if (wr && paddr == tx_cfg_pkg::ADDR_OS_LOAD_TRIM)
      overshoot_and_load_trim <= wbyte & tx_cfg_pkg::WMASK_OS_LOAD_TRIM;
  end

  //////////////////////////////////////////////////////////////////////////////
  // field extraction

  logic       driver_two_invert;
  logic       driver_one_invert;
  logic       drivers_enable;
  logic [2:0] driver_output_mode;
  logic [1:0] carrier_level_reduction;
  logic       cw_max;
  logic       modulation_invert;
  logic [1:0] modulation_source_select;
  logic [3:0] second_overshoot_length;

  assign driver_two_invert        = driver_mode[tx_cfg_pkg::DM_INV_TWO];
  assign driver_one_invert        = driver_mode[tx_cfg_pkg::DM_INV_ONE];
  assign drivers_enable           = driver_mode[tx_cfg_pkg::DM_ENABLE];
  assign driver_output_mode       = driver_mode[tx_cfg_pkg::DM_MODE_LSB +: 3];
  assign carrier_level_reduction  = carrier_amplitude[tx_cfg_pkg::AMP_LVL_LSB +: 2];
  assign cw_max                   = modulation_control[tx_cfg_pkg::MC_CW_MAX];
  assign modulation_invert        = modulation_control[tx_cfg_pkg::MC_INVERT];
  assign modulation_source_select = modulation_control[tx_cfg_pkg::MC_SEL_LSB +: 2];
  assign second_overshoot_length  = modulation_control[tx_cfg_pkg::MC_OS2_LSB +: 4];

  //////////////////////////////////////////////////////////////////////////////
  // configuration handed to the analog driver

  // maximum amplitude wins; the reduction code is masked so the analog side
  // never sees a stale setting
  assign amplitude_cfg.cw_max           = cw_max;
  assign amplitude_cfg.level_reduction  = cw_max ? 2'h0 : carrier_level_reduction;
  assign amplitude_cfg.residual_carrier =
    carrier_amplitude[tx_cfg_pkg::AMP_RES_LSB +: 5];

  assign overshoot_cfg.first_overshoot_value =
    overshoot_and_load_trim[tx_cfg_pkg::LT_OS1_LSB +: 4];
  assign overshoot_cfg.load_current_trim =
    overshoot_and_load_trim[tx_cfg_pkg::LT_TRIM_LSB +: 4];
  assign overshoot_cfg.second_overshoot_length = second_overshoot_length;

  //////////////////////////////////////////////////////////////////////////////
  // modulation source

  logic mod_src;
  logic mod_sig;

  always_comb
  begin
    case (modulation_source_select)
      tx_cfg_pkg::SRC_ENVELOPE: mod_src = internal_transmit_envelope;
      tx_cfg_pkg::SRC_EXTERNAL: mod_src = external_modulation_in;
      default:                  mod_src = 1'b0;
    endcase
  end

  assign mod_sig = mod_src ^ modulation_invert;

  //////////////////////////////////////////////////////////////////////////////
  // overshoot extension: modulation is held for a number of carrier clocks
  // after the source releases it

  tx_cfg_pkg::os_state_t os_state;
  tx_cfg_pkg::os_state_t next_os_state;
  logic [3:0]            os_count;
  logic [3:0]            next_os_count;

  always_comb
  begin
    next_os_state = os_state;
    next_os_count = os_count;
    case (os_state)
      tx_cfg_pkg::OS_IDLE:
      begin
        if (mod_sig)
          next_os_state = tx_cfg_pkg::OS_MOD;
      end
      tx_cfg_pkg::OS_MOD:
      begin
        if (!mod_sig && second_overshoot_length == 4'h0)
          next_os_state = tx_cfg_pkg::OS_IDLE;
        else if (!mod_sig)
        begin
          next_os_state = tx_cfg_pkg::OS_EXTEND;
          next_os_count = second_overshoot_length;
        end
      end
      tx_cfg_pkg::OS_EXTEND:
      begin
        if (mod_sig)
          next_os_state = tx_cfg_pkg::OS_MOD;
        else if (carrier_tick && os_count == 4'h1)
          next_os_state = tx_cfg_pkg::OS_IDLE;
        else if (carrier_tick)
          next_os_count = os_count - 4'h1;
      end
      default:
        next_os_state = tx_cfg_pkg::OS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      os_state <= tx_cfg_pkg::OS_IDLE;
    else
      os_state <= next_os_state;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      os_count <= 4'h0;
    else
      os_count <= next_os_count;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      modulation_out <= 1'b0;
    else
      modulation_out <= (next_os_state != tx_cfg_pkg::OS_IDLE);
  end

  //////////////////////////////////////////////////////////////////////////////
  // driver pins

  driver_stage u_driver_one
  (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (carrier_in),
    .invert  (driver_one_invert),
    .enable  (drivers_enable),
    .mode    (driver_output_mode),
    .pin_out (driver_pin_one_out),
    .pin_oe  (driver_pin_one_oe)
  );

  driver_stage u_driver_two
  (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (carrier_in),
    .invert  (driver_two_invert),
    .enable  (drivers_enable),
    .mode    (driver_output_mode),
    .pin_out (driver_pin_two_out),
    .pin_oe  (driver_pin_two_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks

  AST_INV_TWO: assert property (@(posedge pclk) disable iff (!presetn)
    (drivers_enable && driver_output_mode == tx_cfg_pkg::MODE_PUSH_PULL
     && driver_two_invert)
    |=> driver_pin_two_out == !$past(carrier_in))
    else $error("second driver pin not inverted");

  AST_INV_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    (drivers_enable && driver_output_mode == tx_cfg_pkg::MODE_PUSH_PULL)
    |=> driver_pin_one_out == ($past(carrier_in) ^ $past(driver_one_invert)))
    else $error("first driver pin level wrong");

  AST_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    !drivers_enable |=> !driver_pin_one_oe && !driver_pin_two_oe)
    else $error("driver pin driven while disabled");

  AST_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    (drivers_enable && driver_output_mode == tx_cfg_pkg::MODE_FIX_HIGH)
    |=> driver_pin_one_out && driver_pin_one_oe && driver_pin_two_out
        && driver_pin_two_oe)
    else $error("fixed high mode not driven");

  AST_CW_MAX: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == tx_cfg_pkg::ADDR_MOD_CONTROL && pwdata[tx_cfg_pkg::MC_CW_MAX])
    |=> amplitude_cfg.cw_max && amplitude_cfg.level_reduction == 2'h0)
    else $error("maximum amplitude does not override reduction");

  AST_RESIDUAL: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == tx_cfg_pkg::ADDR_CARRIER_AMP)
    |=> amplitude_cfg.residual_carrier == $past(pwdata[4:0]))
    else $error("residual carrier not updated");

  AST_MOD_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    mod_sig |=> modulation_out)
    else $error("modulation output missed its source");

  AST_NO_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
    (os_state == tx_cfg_pkg::OS_IDLE && !modulation_invert
     && modulation_source_select == tx_cfg_pkg::SRC_NONE)
    |=> !modulation_out)
    else $error("modulation without a source");

  AST_EXTEND_END: assert property (@(posedge pclk) disable iff (!presetn)
    (os_state == tx_cfg_pkg::OS_EXTEND && !mod_sig && carrier_tick
     && os_count == 4'h1)
    |=> !modulation_out && os_state == tx_cfg_pkg::OS_IDLE)
    else $error("overshoot extension did not end");

  AST_EXTEND_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (os_state == tx_cfg_pkg::OS_MOD && !mod_sig && second_overshoot_length != 4'h0)
    |=> modulation_out && os_count == $past(second_overshoot_length))
    else $error("overshoot extension not started");

  AST_TRIM: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == tx_cfg_pkg::ADDR_OS_LOAD_TRIM)
    |=> overshoot_cfg.load_current_trim == $past(pwdata[3:0])
        && overshoot_cfg.first_overshoot_value == $past(pwdata[7:4]))
    else $error("load register fields not updated");

  AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && (paddr == tx_cfg_pkg::ADDR_DRIVER_MODE
               || paddr == tx_cfg_pkg::ADDR_CARRIER_AMP))
    |=> prdata[31:8] == 24'h00_0000
        && (prdata[7:0] & ($past(paddr) == tx_cfg_pkg::ADDR_DRIVER_MODE ? 8'h30 : 8'h20))
           == 8'h00)
    else $error("reserved bits read nonzero");

endmodule

// [bench/tb_rf_transmitter_config_regs.sv]
// self-checking testbench for the transmitter configuration register bank
`timescale 1ns/1ps
module tb_rf_transmitter_config_regs;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rexp;
  } row_t;

  logic                       pclk;
  logic                       presetn;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [11:0]                paddr;
  logic [31:0]                pwdata;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic                       carrier_in;
  logic                       carrier_tick;
  logic                       env;
  logic                       ext;
  logic                       one_out;
  logic                       one_oe;
  logic                       two_out;
  logic                       two_oe;
  logic                       modulation_out;
  tx_cfg_pkg::amplitude_cfg_t amplitude_cfg;
  tx_cfg_pkg::overshoot_cfg_t overshoot_cfg;
  logic [31:0]                rd;
  logic                       err;
  int                         error_cnt = 0;
  int                         n_checks = 0;
  int                         cycles = 0;

  // reserved bits are written as ones and must read back as zero
  row_t rows [6] = '{
    '{tx_cfg_pkg::ADDR_DRIVER_MODE, 8'hff, 8'hcf},
    '{tx_cfg_pkg::ADDR_CARRIER_AMP, 8'hff, 8'hdf},
    '{tx_cfg_pkg::ADDR_MOD_CONTROL, 8'ha5, 8'ha5},
    '{tx_cfg_pkg::ADDR_OS_LOAD_TRIM, 8'h3c, 8'h3c},
    '{tx_cfg_pkg::ADDR_DRIVER_MODE, 8'h30, 8'h00},
    '{tx_cfg_pkg::ADDR_CARRIER_AMP, 8'h20, 8'h00}
  };

  transmitter_config_regs dut
  (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .psel                       (psel),
    .penable                    (penable),
    .pwrite                     (pwrite),
    .paddr                      (paddr),
    .pwdata                     (pwdata),
    .prdata                     (prdata),
    .pready                     (pready),
    .pslverr                    (pslverr),
    .carrier_in                 (carrier_in),
    .carrier_tick               (carrier_tick),
    .internal_transmit_envelope (env),
    .external_modulation_in     (ext),
    .driver_pin_one_out         (one_out),
    .driver_pin_one_oe          (one_oe),
    .driver_pin_two_out         (two_out),
    .driver_pin_two_oe          (two_oe),
    .modulation_out             (modulation_out),
    .amplitude_cfg              (amplitude_cfg),
    .overshoot_cfg              (overshoot_cfg)
  );

  always #20 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // run is well under a thousand cycles; the ceiling leaves margin
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits on pready, the global timeout bounds it
  task automatic apb(input logic [11:0] a, input logic wr, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    chk_val(rd, {24'h00_0000, e});
  endtask

  task automatic chk_pins(input logic [1:0] e1, input logic [1:0] e2);
    chk_val(32'({one_out, one_oe}), 32'(e1));
    chk_val(32'({two_out, two_oe}), 32'(e2));
  endtask

  task automatic tick();
    @(posedge pclk);
    carrier_tick <= 1'b1;
    @(posedge pclk);
    carrier_tick <= 1'b0;
  endtask

  // expected {out, oe} for a mode code and pin data
  function automatic logic [1:0] pin_exp(input logic [2:0] m, input logic d);
    case (m)
      tx_cfg_pkg::MODE_OPEN_DRAIN: pin_exp = {1'b0, ~d};
      tx_cfg_pkg::MODE_PUSH_PULL:  pin_exp = {d, 1'b1};
      tx_cfg_pkg::MODE_FIX_LOW:    pin_exp = 2'h1;
      tx_cfg_pkg::MODE_FIX_HIGH:   pin_exp = 2'h3;
      default:                     pin_exp = 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    carrier_in = 1'b0;
    carrier_tick = 1'b0;
    env = 1'b0;
    ext = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rdchk(rows[i].addr, rows[i].rexp);
    end
    // every mode code software may use, with both pin data levels
    for (int m = 0; m < 8; m++)
      for (int c = 0; c < 2; c++)
      begin
        if (m == 3 || m == 6)
          continue;
        wr(tx_cfg_pkg::ADDR_DRIVER_MODE, 8'(8 + m));
        @(posedge pclk);
        carrier_in <= c[0];
        repeat (4) @(posedge pclk);
        chk_pins(pin_exp(m[2:0], c[0]), pin_exp(m[2:0], c[0]));
      end
    wr(tx_cfg_pkg::ADDR_DRIVER_MODE, 8'h8a);
    repeat (3) @(posedge pclk);
    chk_pins(2'h3, 2'h1);
    wr(tx_cfg_pkg::ADDR_DRIVER_MODE, 8'h4a);
    repeat (3) @(posedge pclk);
    chk_pins(2'h1, 2'h3);
    wr(tx_cfg_pkg::ADDR_DRIVER_MODE, 8'h42);
    repeat (3) @(posedge pclk);
    chk_pins(2'h0, 2'h0);
    // each source and invert setting against all input combinations
    for (int s = 0; s < 4; s++)
      for (int v = 0; v < 2; v++)
      begin
        wr(tx_cfg_pkg::ADDR_MOD_CONTROL, 8'(s | (v << 2)));
        for (int k = 0; k < 4; k++)
        begin
          @(posedge pclk);
          env <= k[0];
          ext <= k[1];
          repeat (3) @(posedge pclk);
          chk_bit(modulation_out, (((s == 1) & k[0]) | ((s == 2) & k[1])) ^ v[0]);
        end
      end
    wr(tx_cfg_pkg::ADDR_CARRIER_AMP, 8'hc3);
    wr(tx_cfg_pkg::ADDR_MOD_CONTROL, 8'h00);
    repeat (3) @(posedge pclk);
    chk_val(32'(amplitude_cfg), 32'h0000_00c3);
    wr(tx_cfg_pkg::ADDR_MOD_CONTROL, 8'h08);
    repeat (3) @(posedge pclk);
    chk_val(32'(amplitude_cfg), 32'h0000_0023);
    wr(tx_cfg_pkg::ADDR_MOD_CONTROL, 8'ha0);
    repeat (3) @(posedge pclk);
    chk_val(32'(overshoot_cfg), 32'h0000_03ac);
    // extension of three carrier ticks after the envelope falls
    wr(tx_cfg_pkg::ADDR_MOD_CONTROL, 8'h31);
    @(posedge pclk);
    env <= 1'b1;
    repeat (3) @(posedge pclk);
    env <= 1'b0;
    repeat (3) @(posedge pclk);
    chk_bit(modulation_out, 1'b1);
    tick();
    tick();
    repeat (2) @(posedge pclk);
    chk_bit(modulation_out, 1'b1);
    tick();
    repeat (3) @(posedge pclk);
    chk_bit(modulation_out, 1'b0);
    // unmapped word is refused and reads zero
    apb(12'h0b0, 1'b0, 8'h00);
    chk_bit(err, 1'b1);
    chk_val(rd, 32'h0000_0000);
    // mid-run reset clears registers and releases the pins
    wr(tx_cfg_pkg::ADDR_DRIVER_MODE, 8'h0a);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_pins(2'h0, 2'h0);
    rdchk(tx_cfg_pkg::ADDR_DRIVER_MODE, tx_cfg_pkg::RST_DRIVER_MODE);
    rdchk(tx_cfg_pkg::ADDR_CARRIER_AMP, tx_cfg_pkg::RST_CARRIER_AMP);
    rdchk(tx_cfg_pkg::ADDR_MOD_CONTROL, tx_cfg_pkg::RST_MOD_CONTROL);
    rdchk(tx_cfg_pkg::ADDR_OS_LOAD_TRIM, tx_cfg_pkg::RST_OS_LOAD_TRIM);
    tally_and_finish();
  end
endmodule
